// ==== design/npg_regs.sv ====
// Received next page register and gigabit configuration register bank
// Operation
// - Received next page register at 0x08
// - Bit 15 shows partner wants more pages
// - Read-only bit 14 shows partner acknowledge
// - Bit 13 message format flag, reset 1
// - Payload resets to null page code
// - Bit 12 shows partner can comply
// - Bit 11 inverts previous exchanged toggle
// - Bits 15:13 select transmit test mode
// - Bit 12 enables manual role forcing
// - Bit 11 forces master or slave
// - Bit 10 advertises multi-port device
// - Bit 9 advertises gigabit full duplex
// - Bit 8 advertises gigabit half duplex
// - Bit 7 runs diagnostic after link loss
// - Bits 6:0 reserved, read zero
module npg_regs #(
  parameter int ADDR_W = 5,
  parameter bit FD_FROM_STRAP = 1'b0
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic PAGE_RX_VALID_I,
  input wire logic [15:0] PAGE_RX_WORD_I,
  input wire logic FD_STRAP_I,
  input wire logic LINK_UP_I,
  output logic DIAG_START_O,
  output logic [2:0] TEST_MODE_O,
  output logic TEST_ACTIVE_O,
  output logic TX_TEST_BIT_O,
  output logic ROLE_FORCED_O,
  output logic ROLE_MASTER_O,
  output logic MULTI_PORT_O,
  output logic ADV_1G_FD_O,
  output logic ADV_1G_HD_O
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 4 || ADDR_W > 5) begin : g_bad_addr
    $error("ADDR_W must be 4 or 5");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match on the management register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
    hit = (5'(a) == off);
  endfunction

  // Merge a write into the writable bits only
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] rnp_ff;
  logic [15:0] nxt_rnp;
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic prev_tog_ff;
  logic init_done_ff;
  logic link_up_ff;
  logic diag_ff;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic [5:0] pat_cnt_ff;
  logic [10:0] lfsr_ff;
  logic [2:0] mode_seen_ff;
  logic tx_bit_ff;
  logic nxt_tx_bit;
  logic wr_rnp;
  logic wr_cfg;
  logic link_fell;
  npg_pkg::npg_mode_t mode;

  assign wr_rnp = REG_WR_I && hit(REG_ADDR_I, npg_pkg::RNP_OFF);
  assign wr_cfg = REG_WR_I && hit(REG_ADDR_I, npg_pkg::CFG_OFF);
  assign mode = npg_pkg::npg_mode_t'(cfg_ff[npg_pkg::CFG_MODE_HI:npg_pkg::CFG_MODE_LO]);
  assign link_fell = link_up_ff && !LINK_UP_I;

  // ----------------------------------------------------------------
  // Received next page register
  // ----------------------------------------------------------------
  // A page arriving with a write wins over the write
  always_comb begin
    nxt_rnp = rnp_ff;
    if (PAGE_RX_VALID_I) begin
      nxt_rnp = PAGE_RX_WORD_I;
      nxt_rnp[npg_pkg::RNP_TOG_BIT] = ~prev_tog_ff;
    end else if (wr_rnp) begin
      nxt_rnp = merge(rnp_ff, REG_WDATA_I, npg_pkg::RNP_WMASK);
    end
  end

  // Register update, reset to the null page
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rnp_ff <= npg_pkg::RNP_RST;
    end else begin
      rnp_ff <= nxt_rnp;
    end
  end

  // Toggle carried by the previously exchanged page
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prev_tog_ff <= 1'b1;
    end else if (PAGE_RX_VALID_I) begin
      prev_tog_ff <= PAGE_RX_WORD_I[npg_pkg::RNP_TOG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Gigabit configuration register
  // ----------------------------------------------------------------
  // Writes touch only bits 15:7
  always_comb begin
    nxt_cfg = cfg_ff;
    if (!init_done_ff && FD_FROM_STRAP) begin
      nxt_cfg[npg_pkg::CFG_FD_BIT] = FD_STRAP_I;
    end else if (wr_cfg) begin
      nxt_cfg = merge(cfg_ff, REG_WDATA_I, npg_pkg::CFG_WMASK);
    end
  end

  // Register update
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_ff <= npg_pkg::CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Strap capture on the first edge after release
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      init_done_ff <= 1'b0;
    end else begin
      init_done_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data one edge after the request, zero when unmapped
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REG_RD_I;
      if (REG_RD_I) begin
        if (hit(REG_ADDR_I, npg_pkg::RNP_OFF)) begin
          rdata_ff <= rnp_ff;
        end else if (hit(REG_ADDR_I, npg_pkg::CFG_OFF)) begin
          rdata_ff <= cfg_ff & npg_pkg::CFG_WMASK;
        end else begin
          rdata_ff <= 16'h0000;
        end
      end
    end
  end

  assign REG_RDATA_O = rdata_ff;
  assign REG_RVALID_O = rvalid_ff;

  // ----------------------------------------------------------------
  // Role, advertisement and test controls
  // ----------------------------------------------------------------
  assign ROLE_FORCED_O = cfg_ff[npg_pkg::CFG_FORCE_BIT];
  assign ROLE_MASTER_O = cfg_ff[npg_pkg::CFG_FORCE_BIT] && cfg_ff[npg_pkg::CFG_MASTER_BIT];
  assign MULTI_PORT_O = cfg_ff[npg_pkg::CFG_MULTI_BIT];
  assign ADV_1G_FD_O = cfg_ff[npg_pkg::CFG_FD_BIT];
  assign ADV_1G_HD_O = cfg_ff[npg_pkg::CFG_HD_BIT];
  assign TEST_MODE_O = cfg_ff[npg_pkg::CFG_MODE_HI:npg_pkg::CFG_MODE_LO];
  assign TEST_ACTIVE_O = (mode != npg_pkg::NPG_MODE_NORMAL);

  // ----------------------------------------------------------------
  // Automatic cable diagnostic launch
  // ----------------------------------------------------------------
  // One pulse per link-down event while enabled
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      link_up_ff <= 1'b0;
      diag_ff <= 1'b0;
    end else begin
      link_up_ff <= LINK_UP_I;
      diag_ff <= link_fell && cfg_ff[npg_pkg::CFG_DIAG_BIT];
    end
  end

  assign DIAG_START_O = diag_ff;

  // ----------------------------------------------------------------
  // Test pattern generator
  // ----------------------------------------------------------------
  // Pattern phase, restarts when the mode changes
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pat_cnt_ff <= 6'h00;
      mode_seen_ff <= 3'h0;
    end else begin
      mode_seen_ff <= TEST_MODE_O;
      if (mode_seen_ff != TEST_MODE_O || !TEST_ACTIVE_O) begin
        pat_cnt_ff <= 6'h00;
      end else begin
        pat_cnt_ff <= pat_cnt_ff + 6'h01;
      end
    end
  end

  // Scrambler stream for idles and analog tests
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      lfsr_ff <= npg_pkg::LFSR_SEED;
    end else if (TEST_ACTIVE_O) begin
      lfsr_ff <= {lfsr_ff[9:0], lfsr_ff[10] ^ lfsr_ff[8]};
    end
  end

  // Pattern bit per mode
  always_comb begin
    unique case (mode)
      npg_pkg::NPG_MODE_NORMAL: nxt_tx_bit = 1'b0;
      npg_pkg::NPG_MODE_WAVE: nxt_tx_bit = lfsr_ff[10];
      npg_pkg::NPG_MODE_JIT_MST: nxt_tx_bit = lfsr_ff[10];
      npg_pkg::NPG_MODE_JIT_SLV: nxt_tx_bit = lfsr_ff[10];
      npg_pkg::NPG_MODE_DIST: nxt_tx_bit = lfsr_ff[10];
      npg_pkg::NPG_MODE_IDLES: nxt_tx_bit = lfsr_ff[10];
      npg_pkg::NPG_MODE_SEQ: nxt_tx_bit = (pat_cnt_ff[1:0] == npg_pkg::SEQ_LAST);
      npg_pkg::NPG_MODE_PULSE: nxt_tx_bit = (pat_cnt_ff == 6'h00);
    endcase
  end

  // Registered pattern output, quiet in normal mode
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tx_bit_ff <= 1'b0;
    end else begin
      tx_bit_ff <= nxt_tx_bit;
    end
  end

  assign TX_TEST_BIT_O = tx_bit_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rnp_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_RD_I && hit(REG_ADDR_I, npg_pkg::RNP_OFF) |=> REG_RVALID_O && REG_RDATA_O == $past(rnp_ff);
  endproperty
  a_rnp_read: assert property (p_rnp_read) else $error("next page read mismatch");

  property p_page_flags;
    @(posedge CLK_I) disable iff (!RST_B_I)
    PAGE_RX_VALID_I |=> rnp_ff[15:12] == $past(PAGE_RX_WORD_I[15:12]);
  endproperty
  a_page_flags: assert property (p_page_flags) else $error("page flags not captured");

  property p_ack_ro;
    @(posedge CLK_I) disable iff (!RST_B_I)
    wr_rnp && !PAGE_RX_VALID_I |=>
      $stable(rnp_ff[npg_pkg::RNP_ACK_BIT]) && $stable(rnp_ff[npg_pkg::RNP_TOG_BIT]);
  endproperty
  a_ack_ro: assert property (p_ack_ro) else $error("read-only page bit written");

  property p_code;
    @(posedge CLK_I) disable iff (!RST_B_I)
    PAGE_RX_VALID_I |=> rnp_ff[npg_pkg::RNP_CODE_HI:0] == $past(PAGE_RX_WORD_I[10:0]);
  endproperty
  a_code: assert property (p_code) else $error("page code not captured");

  property p_toggle;
    @(posedge CLK_I) disable iff (!RST_B_I)
    PAGE_RX_VALID_I ##1 PAGE_RX_VALID_I |=>
      rnp_ff[npg_pkg::RNP_TOG_BIT] == !$past(PAGE_RX_WORD_I[npg_pkg::RNP_TOG_BIT], 2);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not inverted");

  property p_mode_wr;
    @(posedge CLK_I) disable iff (!RST_B_I)
    wr_cfg && init_done_ff |=> TEST_MODE_O == $past(REG_WDATA_I[15:13]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("test mode not written");

  property p_role;
    @(posedge CLK_I) disable iff (!RST_B_I)
    ROLE_MASTER_O |-> ROLE_FORCED_O && cfg_ff[npg_pkg::CFG_MASTER_BIT];
  endproperty
  a_role: assert property (p_role) else $error("master forced without enable");

  // Role outputs follow the written role bits
  property p_role_wr;
    @(posedge CLK_I) disable iff (!RST_B_I)
    wr_cfg && init_done_ff |=>
      ROLE_FORCED_O == $past(REG_WDATA_I[npg_pkg::CFG_FORCE_BIT]) &&
      ROLE_MASTER_O == ($past(REG_WDATA_I[npg_pkg::CFG_FORCE_BIT]) &&
        $past(REG_WDATA_I[npg_pkg::CFG_MASTER_BIT]));
  endproperty
  a_role_wr: assert property (p_role_wr) else $error("role outputs not written");

  // Advertisement outputs follow the written bits
  property p_adv_wr;
    @(posedge CLK_I) disable iff (!RST_B_I)
    wr_cfg && init_done_ff |=>
      {MULTI_PORT_O, ADV_1G_FD_O, ADV_1G_HD_O} ==
        $past(REG_WDATA_I[npg_pkg::CFG_MULTI_BIT:npg_pkg::CFG_HD_BIT]);
  endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("advertisement not written");

  property p_diag;
    @(posedge CLK_I) disable iff (!RST_B_I)
    link_fell && cfg_ff[npg_pkg::CFG_DIAG_BIT] |=> DIAG_START_O ##1 !DIAG_START_O;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic not launched");

  // No launch while the automatic diagnostic is off
  property p_diag_off;
    @(posedge CLK_I) disable iff (!RST_B_I)
    !cfg_ff[npg_pkg::CFG_DIAG_BIT] |=> !DIAG_START_O;
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("diagnostic launched while off");

  property p_rsvd;
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_RD_I && hit(REG_ADDR_I, npg_pkg::CFG_OFF) |=> REG_RDATA_O[6:0] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");

  property p_pulse;
    @(posedge CLK_I) disable iff (!RST_B_I)
    $rose(TX_TEST_BIT_O) && mode == npg_pkg::NPG_MODE_PULSE && $stable(TEST_MODE_O)
      |=> (!TX_TEST_BIT_O || mode != npg_pkg::NPG_MODE_PULSE)[*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not followed by zeros");

  property p_normal_quiet;
    @(posedge CLK_I) disable iff (!RST_B_I)
    !TEST_ACTIVE_O ##1 !TEST_ACTIVE_O |-> !TX_TEST_BIT_O;
  endproperty
  a_normal_quiet: assert property (p_normal_quiet) else $error("pattern in normal mode");

endmodule // npg_regs

// ==== design/npg_pkg.sv ====
// Constants for the received next page and gigabit configuration registers
package npg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] RNP_OFF = 5'h08;
  localparam logic [4:0] CFG_OFF = 5'h09;

  // ----------------------------------------------------------------
  // Received next page fields
  // ----------------------------------------------------------------
  localparam int RNP_MORE_BIT = 15;
  localparam int RNP_ACK_BIT = 14;
  localparam int RNP_MSG_BIT = 13;
  localparam int RNP_COMPLY_BIT = 12;
  localparam int RNP_TOG_BIT = 11;
  localparam int RNP_CODE_HI = 10;
  localparam logic [15:0] RNP_RST = 16'h2001;
  localparam logic [15:0] RNP_WMASK = 16'hB7FF;

  // ----------------------------------------------------------------
  // Gigabit configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_MODE_HI = 15;
  localparam int CFG_MODE_LO = 13;
  localparam int CFG_FORCE_BIT = 12;
  localparam int CFG_MASTER_BIT = 11;
  localparam int CFG_MULTI_BIT = 10;
  localparam int CFG_FD_BIT = 9;
  localparam int CFG_HD_BIT = 8;
  localparam int CFG_DIAG_BIT = 7;
  localparam logic [15:0] CFG_RST = 16'h0300;
  localparam logic [15:0] CFG_WMASK = 16'hFF80;

  // ----------------------------------------------------------------
  // Transmit test modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NPG_MODE_NORMAL = 3'h0,
    NPG_MODE_WAVE = 3'h1,
    NPG_MODE_JIT_MST = 3'h2,
    NPG_MODE_JIT_SLV = 3'h3,
    NPG_MODE_DIST = 3'h4,
    NPG_MODE_IDLES = 3'h5,
    NPG_MODE_SEQ = 3'h6,
    NPG_MODE_PULSE = 3'h7
  } npg_mode_t;

  // ----------------------------------------------------------------
  // Test pattern timing
  // ----------------------------------------------------------------
  localparam logic [5:0] PULSE_ZEROS = 6'h3F;
  localparam logic [1:0] SEQ_LAST = 2'h3;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;

endpackage

// ==== tb/npg_partner.sv ====
// Remote link partner model: delivers next page words and link status
module npg_partner (
  input wire logic clk_i,
  output logic page_valid_o,
  output logic [15:0] page_word_o,
  output logic link_up_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle partner with the link up
  initial begin
    page_valid_o = 1'b0;
    page_word_o = 16'h0000;
    link_up_o = 1'b1;
  end

  // One link code word, strobed for a single clock
  task automatic send(input logic [15:0] w);
    page_valid_o = 1'b1;
    page_word_o = w;
    @(negedge clk_i);
    page_valid_o = 1'b0;
    page_word_o = ~w; // Stale word must not look valid
  endtask

  // Two link code words on consecutive clocks
  task automatic send2(input logic [15:0] a, input logic [15:0] b);
    page_valid_o = 1'b1;
    page_word_o = a;
    @(negedge clk_i);
    page_word_o = b;
    @(negedge clk_i);
    page_valid_o = 1'b0;
    page_word_o = ~b;
  endtask

  // Link status level change
  task automatic link(input logic v);
    link_up_o = v;
    @(negedge clk_i);
  endtask
endmodule // npg_partner

// ==== tb/tb_top.sv ====
// Self-checking bench for the received page and gigabit config registers
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] addr = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdata, pw, cfg, rnp, w, w2;
  logic rvalid, pv, lu, diag, tact, tbit, rf, rm, mp, afd, ahd, prev_tog;
  logic [2:0] tmode;
  logic [15:0] exp_q[$];
  string nam_q[$];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  always #4 clk = ~clk;

  npg_regs npg_regs_i (
    .CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .PAGE_RX_VALID_I(pv),
    .PAGE_RX_WORD_I(pw), .FD_STRAP_I(1'b0), .LINK_UP_I(lu), .DIAG_START_O(diag),
    .TEST_MODE_O(tmode), .TEST_ACTIVE_O(tact), .TX_TEST_BIT_O(tbit), .ROLE_FORCED_O(rf),
    .ROLE_MASTER_O(rm), .MULTI_PORT_O(mp), .ADV_1G_FD_O(afd), .ADV_1G_HD_O(ahd));

  npg_partner npg_partner_i (.clk_i(clk), .page_valid_o(pv), .page_word_o(pw), .link_up_o(lu));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Read strobe with its expected answer noted
  task automatic reg_rd(input logic [4:0] a, input logic [15:0] e, input string nm);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(e);
    nam_q.push_back(nm);
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Count cycles with a high bit over a window, starting at this edge
  task automatic count_high(input int len, input bit use_diag);
    n = 0;
    repeat (len) begin
      n += int'((use_diag ? diag : tbit) === 1'b1);
      @(negedge clk);
    end
  endtask

  // Read answer monitor, oldest note first
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) check(nam_q.pop_front(), rdata, exp_q.pop_front());
      else check("unexpected read", 16'h0001, 16'h0000);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      check("timeout", 16'h0001, 16'h0000);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hFF799912));
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check("adv duplex", {14'h0000, afd, ahd}, 16'h0003);
    reg_rd(npg_pkg::RNP_OFF, 16'h2001, "page reset");
    reg_rd(npg_pkg::CFG_OFF, 16'h0300, "cfg reset");
    reg_rd(5'h1F, 16'h0000, "unmapped");
    // Partner pages, toggle stored inverted from the previous word
    prev_tog = 1'b1;
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom());
      npg_partner_i.send(w);
      rnp = {w[15:12], ~prev_tog, w[10:0]};
      prev_tog = w[11];
      reg_rd(npg_pkg::RNP_OFF, rnp, "page rx");
    end
    // Back-to-back pages, second one stores the first word's toggle inverted
    w = 16'($urandom());
    w2 = 16'($urandom());
    npg_partner_i.send2(w, w2);
    rnp = {w2[15:12], ~w[11], w2[10:0]};
    reg_rd(npg_pkg::RNP_OFF, rnp, "page pair");
    // Software write cannot touch acknowledge or toggle
    w = 16'($urandom());
    reg_wr(npg_pkg::RNP_OFF, w);
    rnp = (rnp & 16'h4800) | (w & 16'hB7FF);
    reg_rd(npg_pkg::RNP_OFF, rnp, "page wr");
    // Every test mode with random role and advertisement bits
    for (int m = 0; m < 8; m++) begin
      cfg = 16'($urandom());
      cfg[15:13] = 3'(m);
      reg_wr(npg_pkg::CFG_OFF, cfg);
      cfg = cfg & 16'hFF80;
      reg_rd(npg_pkg::CFG_OFF, cfg, "cfg");
      check("mode", {13'h0000, tmode}, {13'h0000, cfg[15:13]});
      check("active", {15'h0000, tact}, {15'h0000, cfg[15:13] != 3'h0});
      check("role", {14'h0000, rf, rm}, {14'h0000, cfg[12], cfg[12] & cfg[11]});
      check("adv", {13'h0000, mp, afd, ahd}, {13'h0000, cfg[10:8]});
      repeat (4) @(negedge clk);
      count_high(128, 1'b0);
      if (m == 0) check("normal ones", 16'(n), 16'h0000);
      else if (m == 6) check("seq ones", 16'(n), 16'h0020);
      else if (m == 7) check("pulse ones", 16'(n), 16'h0002);
      else check("scrambled live", {15'h0000, n > 0}, 16'h0001);
    end
    // Link loss with automatic diagnostic off, then on
    for (int b = 0; b < 2; b++) begin
      reg_wr(npg_pkg::CFG_OFF, {8'h00, 1'(b), 7'h00});
      npg_partner_i.link(1'b0);
      count_high(8, 1'b1);
      check("diag pulses", 16'(n), 16'(b));
      npg_partner_i.link(1'b1);
      repeat (2) @(negedge clk);
    end
    test_done();
  end
endmodule // tb_top
